// *** hw/ptp_csr_pkg.sv ***
/*
  Constants for the timestamp configuration register bank: word offsets,
  field positions, widths and values after reset for both directions.
  Assumes a 12-bit word address bus where one offset is one 32-bit word.
*/
package ptp_csr_pkg;

  // Bus widths.
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Transmit range word offsets.
  localparam logic [11:0] TX_REV_OFS     = 12'hA00;
  localparam logic [11:0] TX_SCRATCH_OFS = 12'hA01;
  localparam logic [11:0] TX_IDENT0_OFS  = 12'hA02;
  localparam logic [11:0] TX_IDENT1_OFS  = 12'hA03;
  localparam logic [11:0] TX_IDENT2_OFS  = 12'hA04;
  localparam logic [11:0] TX_PERIOD_OFS  = 12'hA05;
  localparam logic [11:0] TX_RSVD_LO_OFS = 12'hA06;
  localparam logic [11:0] TX_RSVD_HI_OFS = 12'hA0A;
  localparam logic [11:0] TX_ASYM_OFS    = 12'hA0B;
  localparam logic [11:0] TX_LAT_OFS     = 12'hA0C;

  // Receive range word offsets.
  localparam logic [11:0] RX_REV_OFS     = 12'hB00;
  localparam logic [11:0] RX_SCRATCH_OFS = 12'hB01;
  localparam logic [11:0] RX_IDENT0_OFS  = 12'hB02;
  localparam logic [11:0] RX_IDENT1_OFS  = 12'hB03;
  localparam logic [11:0] RX_IDENT2_OFS  = 12'hB04;
  localparam logic [11:0] RX_PERIOD_OFS  = 12'hB05;
  localparam logic [11:0] RX_LAT_OFS     = 12'hB06;

  // Clock period field: whole ns above a 16-bit fraction.
  localparam int PERIOD_W    = 20;
  localparam int FRAC_W      = 16;
  localparam int PERIOD_NS_LSB = 16;

  // Asymmetry field positions.
  localparam int ASYM_W      = 19;
  localparam int ASYM_EN_BIT = 18;
  localparam int ASYM_SUB_BIT = 17;
  localparam int ASYM_MAG_W  = 17;

  // Values after reset.
  localparam logic [19:0] PERIOD_RST  = 20'h28F5C;
  localparam logic [18:0] ASYM_RST    = 19'h00000;
  localparam logic [31:0] WORD_RST    = 32'h00000000;

endpackage

// *** hw/ptp_timestamp_csr_bank.sv ***
/*
  Configuration and identification register bank for the transmit and
  receive timestamp paths, plus the asymmetry correction of the final
  delay. Assumes a single-clock register port whose master holds strobes
  for one cycle, never raises both at once, and reads data one cycle later.
  The final delay arrives from logic on the same clock, so it is not
  synchronised.
*/
module ptp_timestamp_csr_bank #(
  parameter int          DELAY_W   = 48,            // Final delay, ns with 16-bit fraction.
  parameter logic [31:0] REVISION  = 32'h00010000,  // Arbitrary value.
  parameter logic [31:0] TX_IDENT0 = 32'h41414141,  // Arbitrary value.
  parameter logic [31:0] TX_IDENT1 = 32'h42424242,  // Arbitrary value.
  parameter logic [31:0] TX_IDENT2 = 32'h43434343,  // Arbitrary value.
  parameter logic [31:0] RX_IDENT0 = 32'h44444444,  // Arbitrary value.
  parameter logic [31:0] RX_IDENT1 = 32'h45454545,  // Arbitrary value.
  parameter logic [31:0] RX_IDENT2 = 32'h46464646   // Arbitrary value.
) (
  input  wire logic                          clk_in,
  input  wire logic                          nrst_in,
  input  wire logic [ptp_csr_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [ptp_csr_pkg::DATA_W-1:0] wdata_in,
  input  wire logic                          wr_in,
  input  wire logic                          rd_in,
  output logic      [ptp_csr_pkg::DATA_W-1:0] rdata_out,
  input  wire logic [DELAY_W-1:0]            final_delay_in,
  output logic      [DELAY_W-1:0]            adjusted_delay_out,
  output logic      [ptp_csr_pkg::PERIOD_W-1:0] tx_period_out,
  output logic      [ptp_csr_pkg::PERIOD_W-1:0] rx_period_out,
  output logic      [ptp_csr_pkg::DATA_W-1:0] tx_latency_out,
  output logic      [ptp_csr_pkg::DATA_W-1:0] rx_latency_out
);
  import ptp_csr_pkg::*;

  // Software-visible storage.
  logic [DATA_W-1:0]   tx_scratch_word;          // Transmit scratch.
  logic [DATA_W-1:0]   rx_scratch_word;          // Receive scratch.
  logic [PERIOD_W-1:0] tx_mac_period;            // Transmit MAC clock period.
  logic [PERIOD_W-1:0] rx_mac_period;            // Receive MAC clock period.
  logic [ASYM_W-1:0]   tx_asymmetry_adjust;      // Enable, direction, magnitude.
  logic [DATA_W-1:0]   tx_serializer_latency;    // Transmit serializer latency.
  logic [DATA_W-1:0]   rx_deserializer_latency;  // Receive deserializer latency.
  logic [DATA_W-1:0]   next_rdata;               // Read mux result.
  logic [DELAY_W-1:0]  adjusted_delay;           // Registered corrected delay.
  logic [DATA_W-1:0]   read_data;                // Registered read data.

  // Applies the asymmetry word to a delay; the magnitude is whole ns, so it
  // is moved above the fraction before it meets the delay.
  function automatic logic [DELAY_W-1:0] apply_asym(
    input logic [DELAY_W-1:0] delay,
    input logic [ASYM_W-1:0]  asym
  );
    logic [DELAY_W-1:0] mag;
    mag = DELAY_W'({asym[ASYM_MAG_W-1:0], {FRAC_W{1'b0}}});
    if (!asym[ASYM_EN_BIT]) begin
      apply_asym = delay;
    end else if (asym[ASYM_SUB_BIT]) begin
      apply_asym = delay - mag;
    end else begin
      apply_asym = delay + mag;
    end
  endfunction

  // Tells whether a word address hits one writable location.
  function automatic logic hit(
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] ofs
  );
    hit = (a == ofs);
  endfunction

  // Scratch words have no side effect beyond storage.
  // scratch write storage
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tx_scratch_word <= WORD_RST;
      rx_scratch_word <= WORD_RST;
    end else if (wr_in) begin
      if (hit(addr_in, TX_SCRATCH_OFS)) begin
        tx_scratch_word <= wdata_in;
      end
      if (hit(addr_in, RX_SCRATCH_OFS)) begin
        rx_scratch_word <= wdata_in;
      end
    end
  end

  // Clock period words; the upper data bits are dropped on purpose.
  // transmit and receive period write
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tx_mac_period <= PERIOD_RST;
      rx_mac_period <= PERIOD_RST;
    end else if (wr_in) begin
      if (hit(addr_in, TX_PERIOD_OFS)) begin
        tx_mac_period <= wdata_in[PERIOD_W-1:0];
      end
      if (hit(addr_in, RX_PERIOD_OFS)) begin
        rx_mac_period <= wdata_in[PERIOD_W-1:0];
      end
    end
  end

  // Asymmetry word; a change takes effect on the next delay sample.
  // asymmetry word storage
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tx_asymmetry_adjust <= ASYM_RST;
    end else if (wr_in && hit(addr_in, TX_ASYM_OFS)) begin
      tx_asymmetry_adjust <= wdata_in[ASYM_W-1:0];
    end
  end

  // Latency words. They reset to zero, not to the recommended values, so
  // software must load them before timestamps are trusted.
  // transmit and receive latency write
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tx_serializer_latency   <= WORD_RST;
      rx_deserializer_latency <= WORD_RST;
    end else if (wr_in) begin
      if (hit(addr_in, TX_LAT_OFS)) begin
        tx_serializer_latency <= wdata_in;
      end
      if (hit(addr_in, RX_LAT_OFS)) begin
        rx_deserializer_latency <= wdata_in;
      end
    end
  end

  // Read decode. Revision and identifier words ignore writes since no
  // storage stands behind them; reserved and unmapped words read zero.
  // read word decode
  always_comb begin
    next_rdata = WORD_RST;
    if (addr_in == TX_REV_OFS || addr_in == RX_REV_OFS) begin
      next_rdata = REVISION;
    end else if (addr_in == TX_SCRATCH_OFS) begin
      next_rdata = tx_scratch_word;
    end else if (addr_in == TX_IDENT0_OFS) begin
      next_rdata = TX_IDENT0;
    end else if (addr_in == TX_IDENT1_OFS) begin
      next_rdata = TX_IDENT1;
    end else if (addr_in == TX_IDENT2_OFS) begin
      next_rdata = TX_IDENT2;
    end else if (addr_in == TX_PERIOD_OFS) begin
      next_rdata = DATA_W'(tx_mac_period);
    end else if (addr_in == TX_ASYM_OFS) begin
      next_rdata = DATA_W'(tx_asymmetry_adjust);
    end else if (addr_in == TX_LAT_OFS) begin
      next_rdata = tx_serializer_latency;
    end else if (addr_in == RX_SCRATCH_OFS) begin
      next_rdata = rx_scratch_word;
    end else if (addr_in == RX_IDENT0_OFS) begin
      next_rdata = RX_IDENT0;
    end else if (addr_in == RX_IDENT1_OFS) begin
      next_rdata = RX_IDENT1;
    end else if (addr_in == RX_IDENT2_OFS) begin
      next_rdata = RX_IDENT2;
    end else if (addr_in == RX_PERIOD_OFS) begin
      next_rdata = DATA_W'(rx_mac_period);
    end else if (addr_in == RX_LAT_OFS) begin
      next_rdata = rx_deserializer_latency;
    end
  end

  // Read data is captured on the strobe and held only for the next cycle;
  // otherwise it returns to zero so stale words are never mistaken.
  // read data capture
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      read_data <= WORD_RST;
    end else if (rd_in) begin
      read_data <= next_rdata;
    end else begin
      read_data <= WORD_RST;
    end
  end

  // Delay correction is one registered stage; wraparound on a subtraction
  // below zero is left to the caller, who owns the delay range.
  // add or subtract
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      adjusted_delay <= '0;
    end else begin
      adjusted_delay <= apply_asym(final_delay_in, tx_asymmetry_adjust);
    end
  end

  // All outputs come straight from the flip-flops above.
  assign rdata_out          = read_data;
  assign adjusted_delay_out = adjusted_delay;
  assign tx_period_out      = tx_mac_period;
  assign rx_period_out      = rx_mac_period;
  assign tx_latency_out     = tx_serializer_latency;
  assign rx_latency_out     = rx_deserializer_latency;

  // Checks on the register behaviour. Each property looks one edge past its last
  // strobe, where the bank promises the effect; AST_RX_PERIOD_WR looks two past its write. Reset disables them
  // all, so the values loaded while reset is low are never judged as writes.
  // Every check watches what the bank drives; the strobes and the address are
  // only used to decide when a check applies.
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  // A period write shows on the output port from the next cycle, with the
  // upper data bits dropped.
  AST_TX_PERIOD_WR: assert property (
    wr_in && addr_in == TX_PERIOD_OFS |=> tx_period_out == $past(wdata_in[PERIOD_W-1:0]))
    else $error("transmit period write lost");

  // The period reads back in the low bits, with the bits above it zero.
  AST_TX_PERIOD_RD: assert property (
    rd_in && addr_in == TX_PERIOD_OFS |=> rdata_out == DATA_W'($past(tx_mac_period)))
    else $error("transmit period readback wrong");

  // The receive period keeps a written value over a following idle cycle.
  AST_RX_PERIOD_WR: assert property (
    wr_in && addr_in == RX_PERIOD_OFS ##1 !wr_in |=> rx_period_out == $past(wdata_in[PERIOD_W-1:0], 2))
    else $error("receive period write lost");

  // Only a write to its own word may change the receive period; a decode
  // slip onto a neighbouring offset would show here first.
  AST_RX_PERIOD_HOLD: assert property (
    !(wr_in && addr_in == RX_PERIOD_OFS) |=> $stable(rx_period_out))
    else $error("receive period changed without a write");

  // The asymmetry word stores the low nineteen bits of a write.
  AST_ASYM_WR: assert property (
    wr_in && addr_in == TX_ASYM_OFS |=> tx_asymmetry_adjust == $past(wdata_in[ASYM_W-1:0]))
    else $error("asymmetry write lost");

  // With the gate clear the delay passes through untouched, one cycle late.
  AST_ASYM_OFF: assert property (
    !tx_asymmetry_adjust[ASYM_EN_BIT] |=> adjusted_delay_out == $past(final_delay_in))
    else $error("delay changed while adjustment off");

  // Direction bit set: the magnitude, in whole ns, is taken off the delay.
  // The magnitude sits above the 16-bit fraction of the delay.
  AST_ASYM_SUB: assert property (
    tx_asymmetry_adjust[ASYM_EN_BIT] && tx_asymmetry_adjust[ASYM_SUB_BIT]
    |=> adjusted_delay_out == $past(final_delay_in)
        - DELAY_W'({$past(tx_asymmetry_adjust[ASYM_MAG_W-1:0]), 16'h0000}))
    else $error("subtraction wrong");

  // Direction bit clear: the magnitude is added on, modulo the delay width.
  AST_ASYM_ADD: assert property (
    tx_asymmetry_adjust[ASYM_EN_BIT] && !tx_asymmetry_adjust[ASYM_SUB_BIT]
    |=> adjusted_delay_out == $past(final_delay_in)
        + DELAY_W'({$past(tx_asymmetry_adjust[ASYM_MAG_W-1:0]), 16'h0000}))
    else $error("addition wrong");

  // A latency write followed at once by a read returns the new word, so the
  // write lands before the read decode looks at the storage.
  AST_TX_LAT_RD: assert property (
    wr_in && addr_in == TX_LAT_OFS ##1 rd_in && addr_in == TX_LAT_OFS
    |=> rdata_out == $past(wdata_in, 2))
    else $error("transmit latency readback wrong");

  // The transmit latency output follows a write one edge later.
  AST_TX_LAT_WR: assert property (
    wr_in && addr_in == TX_LAT_OFS |=> tx_latency_out == $past(wdata_in))
    else $error("transmit latency write lost");

  // The receive latency output does the same for its own word.
  AST_RX_LAT_WR: assert property (
    wr_in && addr_in == RX_LAT_OFS |=> rx_latency_out == $past(wdata_in))
    else $error("receive latency write lost");

  // Scratch words store a write whole and return it on a later read.
  AST_TX_SCRATCH_WR: assert property (
    wr_in && addr_in == TX_SCRATCH_OFS |=> tx_scratch_word == $past(wdata_in))
    else $error("scratch write lost");

  AST_SCRATCH_RD: assert property (
    rd_in && addr_in == RX_SCRATCH_OFS |=> rdata_out == $past(rx_scratch_word))
    else $error("scratch readback wrong");

  // Identifier words are constants on both sides and ignore writes.
  AST_IDENT_RD: assert property (
    rd_in && addr_in == TX_IDENT2_OFS |=> rdata_out == TX_IDENT2)
    else $error("identifier word wrong");

  AST_RX_IDENT_RD: assert property (
    rd_in && addr_in == RX_IDENT0_OFS |=> rdata_out == RX_IDENT0)
    else $error("receive identifier word wrong");

  // The revision word stands at the base of each range.
  AST_REV_RD: assert property (
    rd_in && addr_in == RX_REV_OFS |=> rdata_out == REVISION)
    else $error("revision word wrong");

  AST_TX_REV_RD: assert property (
    rd_in && addr_in == TX_REV_OFS |=> rdata_out == REVISION)
    else $error("transmit revision word wrong");

  // Reserved words read zero.
  AST_RSVD_RD: assert property (
    rd_in && addr_in >= TX_RSVD_LO_OFS && addr_in <= TX_RSVD_HI_OFS |=> rdata_out == 32'h0)
    else $error("reserved word not zero");

  // The port also reads zero between reads, so that software polling the
  // data lines cannot take a stale word for a fresh one.
  AST_RD_IDLE: assert property (
    !rd_in |=> rdata_out == 32'h0)
    else $error("read data not zero outside a read");

  // Main scenarios: each adjustment direction, scratch use, reads in a row
  // and a read straight after a write.
  COV_SUB: cover property (tx_asymmetry_adjust[ASYM_EN_BIT] && tx_asymmetry_adjust[ASYM_SUB_BIT]);
  COV_ADD: cover property (
    tx_asymmetry_adjust[ASYM_EN_BIT] && !tx_asymmetry_adjust[ASYM_SUB_BIT]);
  COV_SCRATCH: cover property (wr_in && addr_in == TX_SCRATCH_OFS ##1 rd_in);
  COV_B2B_RD: cover property (rd_in ##1 rd_in ##1 rd_in);
  COV_WR_RD: cover property (wr_in ##1 rd_in);

endmodule

// *** testbench/test_ptp_timestamp_csr_bank.sv ***
/*
  Self-checking bench for the timestamp register bank: reset values,
  read-write and read-only words, reserved space and the asymmetry path.
  Assumes the bank answers reads one cycle after the strobe with no wait.
*/
module test_ptp_timestamp_csr_bank;
  timeunit 1ns;
  timeprecision 1ps;
  import ptp_csr_pkg::*;

  localparam logic [31:0] REV_VAL = 32'h0A0B0C0D;  // Arbitrary value.

  logic        clk_in;          // Bank clock, 5 ns period.
  logic        nrst_in;         // Reset, active low.
  logic [11:0] addr_in;         // Word address.
  logic [31:0] wdata_in;        // Write data.
  logic        wr_in;           // Write strobe.
  logic        rd_in;           // Read strobe.
  logic [31:0] rdata_out;       // Read data.
  logic [47:0] final_delay_in;  // Raw final delay.
  logic [47:0] adjusted_delay_out;
  logic [19:0] tx_period_out;
  logic [19:0] rx_period_out;
  logic [31:0] tx_latency_out;
  logic [31:0] rx_latency_out;
  int          error_cnt;       // Mismatches seen.
  int          n_compared;      // Comparisons made.
  logic [31:0] rd_val;          // Last word read back.

  ptp_timestamp_csr_bank #(
    .REVISION (REV_VAL)
  ) u_ptp_timestamp_csr_bank (
    .clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .final_delay_in(final_delay_in), .adjusted_delay_out(adjusted_delay_out),
    .tx_period_out(tx_period_out), .rx_period_out(rx_period_out),
    .tx_latency_out(tx_latency_out), .rx_latency_out(rx_latency_out));

  // Free-running clock.
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  // Expected identifier word; index 0..2 transmit, 3..5 receive.
  function automatic logic [31:0] ident_exp(int i);
    return 32'h41414141 + i * 32'h01010101;
  endfunction

  // Compares one value and counts the outcome.
  task automatic chk(logic [47:0] seen, logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle write; the strobe drops at the next edge.
  task automatic wr(logic [11:0] a, logic [31:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1; addr_in <= a; wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  // One-cycle read; data is sampled in the only cycle where it stands.
  task automatic rd_chk(logic [11:0] a, logic [31:0] exp);
    @(posedge clk_in);
    rd_in <= 1'b1; addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 rd_val = rdata_out;
    chk({16'h0, rd_val}, {16'h0, exp});
  endtask

  // Values after reset, read and seen on the period outputs.
  task automatic scen_reset;
    rd_chk(TX_REV_OFS, REV_VAL);
    rd_chk(RX_REV_OFS, REV_VAL);
    for (int i = 0; i < 3; i++) begin
      rd_chk(TX_IDENT0_OFS + 12'(i), ident_exp(i));
      rd_chk(RX_IDENT0_OFS + 12'(i), ident_exp(i + 3));
    end
    rd_chk(TX_SCRATCH_OFS, 32'h0);
    rd_chk(RX_SCRATCH_OFS, 32'h0);
    rd_chk(TX_PERIOD_OFS, 32'h00028F5C);
    rd_chk(RX_PERIOD_OFS, 32'h00028F5C);
    rd_chk(TX_ASYM_OFS, 32'h0);
    rd_chk(TX_LAT_OFS, 32'h0);
    rd_chk(RX_LAT_OFS, 32'h0);
    chk(48'(tx_period_out), 48'h28F5C);
    chk(48'(rx_period_out), 48'h28F5C);
  endtask

  // Writable words, writes in a row with an idle cycle between, dropped upper bits.
  task automatic scen_rw;
    wr(TX_SCRATCH_OFS, 32'hA5A55A5A);
    wr(RX_SCRATCH_OFS, 32'h12345678);
    rd_chk(TX_SCRATCH_OFS, 32'hA5A55A5A);
    rd_chk(RX_SCRATCH_OFS, 32'h12345678);
    wr(TX_PERIOD_OFS, 32'hFFFFFFFF);
    wr(RX_PERIOD_OFS, 32'h00033333);
    rd_chk(TX_PERIOD_OFS, 32'h000FFFFF);
    rd_chk(RX_PERIOD_OFS, 32'h00033333);
    chk(48'(tx_period_out), 48'hFFFFF);
    chk(48'(rx_period_out), 48'h33333);
    wr(TX_LAT_OFS, 32'h0007428F);
    wr(RX_LAT_OFS, 32'h0003FA1C);
    rd_chk(TX_LAT_OFS, 32'h0007428F);
    rd_chk(RX_LAT_OFS, 32'h0003FA1C);
    chk(48'(tx_latency_out), 48'h0007428F);
    chk(48'(rx_latency_out), 48'h0003FA1C);
    wr(TX_ASYM_OFS, 32'hFFFFFFFF);
    rd_chk(TX_ASYM_OFS, 32'h0007FFFF);
  endtask

  // Read-only, reserved and unmapped words ignore writes.
  task automatic scen_ro;
    for (int i = 0; i < 5; i++) begin
      wr(TX_REV_OFS + 12'(i), 32'hFFFFFFFF);
      wr(RX_REV_OFS + 12'(i), 32'hFFFFFFFF);
    end
    for (logic [11:0] a = TX_RSVD_LO_OFS; a <= TX_RSVD_HI_OFS; a++) begin
      wr(a, 32'hFFFFFFFF);
      rd_chk(a, 32'h0);
    end
    wr(12'hA0D, 32'hFFFFFFFF);
    rd_chk(12'hA0D, 32'h0);
    rd_chk(TX_REV_OFS, REV_VAL);
    rd_chk(RX_REV_OFS, REV_VAL);
    for (int i = 0; i < 3; i++) begin
      rd_chk(TX_IDENT0_OFS + 12'(i), ident_exp(i));
      rd_chk(RX_IDENT0_OFS + 12'(i), ident_exp(i + 3));
    end
  endtask

  // A write followed at once by a read, then the idle port reads zero.
  task automatic scen_b2b;
    @(posedge clk_in);
    wr_in <= 1'b1; addr_in <= TX_LAT_OFS; wdata_in <= 32'h00011234;
    @(posedge clk_in);
    wr_in <= 1'b0; rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk({16'h0, rdata_out}, {16'h0, 32'h00011234});
    @(posedge clk_in);
    #1 chk({16'h0, rdata_out}, 48'h0);
  endtask

  // One delay through the asymmetry path; expectation built here.
  task automatic asym_case(logic [18:0] asym, logic [47:0] d);
    logic [47:0] m;
    logic [47:0] exp;
    m   = {31'h0, asym[16:0]} << 16;
    exp = !asym[18] ? d : (asym[17] ? d - m : d + m);
    wr(TX_ASYM_OFS, {13'h0, asym});
    @(posedge clk_in);
    final_delay_in <= d;
    @(posedge clk_in);
    #1 chk(adjusted_delay_out, exp);
  endtask

  // Gate, direction, largest magnitude and wrap below zero.
  task automatic scen_asym;
    asym_case(19'h00005, 48'h000012340000);
    asym_case(19'h40005, 48'h000012340000);
    asym_case(19'h60005, 48'h000012340000);
    asym_case(19'h5FFFF, 48'h000000018000);
    asym_case(19'h7FFFF, 48'h000100000000);
    asym_case(19'h60001, 48'h000000000000);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic complete_run;
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Watchdog well beyond the 150 or so cycles the tests need.
  initial begin
    #100us;
    error_cnt++;
    complete_run();
  end

  // Main sequence.
  initial begin
    error_cnt = 0; n_compared = 0;
    nrst_in = 1'b0; wr_in = 1'b0; rd_in = 1'b0;
    addr_in = 12'h000; wdata_in = 32'h0; final_delay_in = 48'h0;
    repeat (4) @(posedge clk_in);
    nrst_in <= 1'b1;
    scen_reset();
    scen_rw();
    scen_ro();
    scen_b2b();
    scen_asym();
    complete_run();
  end
endmodule
